// [src/ei_consts.svh]
// Notes on behaviour
// - Four start sources: local crank, CAN crank, CAN external start, service.
// - Injection stays off until engine speed reaches 50 rpm.
// - Local crank request refused while ignition is off.
// - Starter drops out above configured maximum cranking speed.
// - Cranking time limited; new attempt only after one second off.
// - Starter locked out while engine speed is above 50 rpm.
// - Starter locked while CAN starting interlock is active.
// - Automatic transmission: start only with neutral position active.
// - External starter type: starter locked, status shows that type.
// - Three driver shorts lock the starter; status shows short from first.
// - A source must drop before it may start the engine again.
// - Local crank request wins over every other source.
// - Local crank without CAN crank: fault and one second delay.
// - Local crank already active at power-up ignored unless reset bridge.
// - CAN crank without local crank: fault and one second delay.
// - CAN external start cranks directly when starter not locked.
// - Braking inhibits injection and governors; hold time then torque ramp.
// - CAN engine-stop demand inhibits injection.
// - CAN starter-interlock demand inhibits injection and locks starter.
// - Governor type 15 idle, 0 to 5 speed control; mode reported.
// - Idle speed reported at 16 rpm per bit.
// - Speed control clamps desired speed between idle and maximum.
`ifndef EI_CONSTS_SVH
`define EI_CONSTS_SVH

`define EI_CLK_NS 10
`define EI_MS_NS 1000000
`define EI_RUN_RPM 16'h0032
`define EI_CONSIST_MS 16'h03E8
`define EI_REST_MS 16'h03E8
`define EI_INIT_MS 16'h012C
`define EI_BRAKE_HOLD_MS 16'h01F4
`define EI_RAMP_STEP 16'h0010
`define EI_SHORT_LIMIT 2'h3
`define EI_GOV_IDLE_TYPE 4'hF
`define EI_GOV_SPEED_MAX 4'h5
`define EI_IDLE_RES_SHIFT 4
`define EI_TIMER_MAX 16'hFFFF

`endif

// [src/ei_pkg.sv]
package ei_pkg;

   typedef enum logic [2:0] {
      STAT_OK,
      STAT_EXT_TYPE,
      STAT_SHORT,
      STAT_LOCKED,
      STAT_CRANKING
   } ei_stat_t;

   typedef enum logic [1:0] {
      GOV_NONE,
      GOV_IDLE,
      GOV_SPEED
   } ei_gov_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_DELAY,
      S_CRANK,
      S_REST
   } ei_state_t;

   // Order matters: bit index is the source number, 3 is highest priority
   typedef struct packed {
      logic local_crank;
      logic can_crank;
      logic ext_start;
      logic service;
   } ei_src_t;

   typedef struct packed {
      logic [15:0] idle_rpm;
      logic [15:0] max_rpm;
      logic [15:0] desired_rpm;
      logic [3:0] gov_type;
   } ei_gov_req_t;

endpackage

// [src/ei_engine_start_interlock.sv]
`timescale 1ns/100ps
`include "ei_consts.svh"

module ei_engine_start_interlock #(
   parameter int MS_CYCLES = `EI_MS_NS / `EI_CLK_NS
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire ei_pkg::ei_src_t src,
   input wire logic ignition_on,
   input wire logic reset_bridge,
   input wire logic [15:0] engine_rpm,
   input wire logic [15:0] max_crank_rpm,
   input wire logic [15:0] max_crank_ms,
   input wire logic can_start_interlock,
   input wire logic can_starter_lock_demand,
   input wire logic can_engine_stop,
   input wire logic brake_active,
   input wire logic auto_transmission,
   input wire logic neutral_position,
   input wire logic starter_type_external,
   input wire logic starter_short,
   input wire ei_pkg::ei_gov_req_t gov_req,
   input wire logic [15:0] torque_demand,
   output logic starter_on,
   output logic inject_enable,
   output logic crank_fault,
   output ei_pkg::ei_stat_t starter_status,
   output ei_pkg::ei_gov_t gov_mode,
   output logic governors_active,
   output logic [7:0] idle_speed_can,
   output logic [15:0] target_rpm,
   output logic [15:0] torque_out
);

   localparam int SRC_LOCAL = 3;
   localparam int SRC_CAN = 2;
   localparam int SRC_EXT = 1;
   localparam int SRC_SVC = 0;

   function automatic logic [3:0] src_onehot(input logic [1:0] idx);
      src_onehot = 4'h1 << idx;
   endfunction

   function automatic logic src_bit(input logic [3:0] s,
                                    input logic [1:0] idx);
      src_bit = |(s & src_onehot(idx));
   endfunction

   function automatic ei_pkg::ei_gov_t gov_decode(input logic [3:0] t);
      if (t == `EI_GOV_IDLE_TYPE) begin
         gov_decode = ei_pkg::GOV_IDLE;
      end else if (t <= `EI_GOV_SPEED_MAX) begin
         gov_decode = ei_pkg::GOV_SPEED;
      end else begin
         gov_decode = ei_pkg::GOV_NONE;
      end
   endfunction

   // Millisecond tick
   logic [16:0] ms_cnt, next_ms_cnt;
   logic ms_tick, next_ms_tick;

   always_comb begin
      if (ms_cnt == 17'(MS_CYCLES - 1)) begin
         next_ms_cnt = 17'h00000;
         next_ms_tick = 1'b1;
      end else begin
         next_ms_cnt = ms_cnt + 17'h00001;
         next_ms_tick = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ms_cnt <= 17'h00000;
         ms_tick <= 1'b0;
      end else begin
         ms_cnt <= next_ms_cnt;
         ms_tick <= next_ms_tick;
      end
   end

   // Starter control
   ei_pkg::ei_state_t state, next_state;
   logic [15:0] timer, next_timer;
   logic [3:0] used, next_used;
   logic [1:0] cur_src, next_cur_src;
   logic [1:0] short_cnt, next_short_cnt;
   logic [15:0] init_timer, next_init_timer;
   logic init_done, next_init_done;
   logic local_block, next_local_block;
   logic next_starter_on;
   logic next_crank_fault;
   ei_pkg::ei_stat_t next_status;
   logic [3:0] req, avail;
   logic local_seen, lock;

   always_comb begin
      req = src;
      // Local request only counts with ignition on and not latched at run-up
      local_seen = src.local_crank & ignition_on & ~local_block
                 & (init_done | reset_bridge);
      avail = req & ~used;
      avail[SRC_LOCAL] = local_seen & ~used[SRC_LOCAL];
      lock = starter_type_external
           | (short_cnt == `EI_SHORT_LIMIT)
           | (engine_rpm > `EI_RUN_RPM)
           | can_start_interlock
           | can_starter_lock_demand
           | (auto_transmission & ~neutral_position);

      next_state = state;
      next_timer = timer;
      next_cur_src = cur_src;
      next_crank_fault = crank_fault;
      next_init_timer = init_timer;
      next_init_done = init_done;
      next_local_block = local_block;
      next_short_cnt = short_cnt;
      // Release first, then any new start sets its bit: set wins
      next_used = used & req;

      if (ms_tick && timer != `EI_TIMER_MAX) begin
         next_timer = timer + 16'h0001;
      end

      if (!init_done && ms_tick) begin
         next_init_timer = init_timer + 16'h0001;
         if (next_init_timer >= `EI_INIT_MS) begin
            next_init_done = 1'b1;
         end
      end
      if (!init_done && src.local_crank && !reset_bridge) begin
         next_local_block = 1'b1;
      end else if (!src.local_crank) begin
         next_local_block = 1'b0;
      end

      if (starter_short && short_cnt != `EI_SHORT_LIMIT) begin
         next_short_cnt = short_cnt + 2'h1;
      end

      case (state)
         ei_pkg::S_IDLE: begin
            if (!lock) begin
               if (avail[SRC_LOCAL]) begin
                  next_cur_src = 2'(SRC_LOCAL);
                  next_timer = 16'h0000;
                  if (!src.can_crank) begin
                     next_state = ei_pkg::S_DELAY;
                  end else begin
                     next_state = ei_pkg::S_CRANK;
                     next_used[SRC_LOCAL] = 1'b1;
                  end
               end else if (avail[SRC_CAN]) begin
                  next_cur_src = 2'(SRC_CAN);
                  next_timer = 16'h0000;
                  if (!local_seen) begin
                     next_state = ei_pkg::S_DELAY;
                  end else begin
                     next_state = ei_pkg::S_CRANK;
                     next_used[SRC_CAN] = 1'b1;
                  end
               end else if (avail[SRC_EXT]) begin
                  next_cur_src = 2'(SRC_EXT);
                  next_timer = 16'h0000;
                  next_state = ei_pkg::S_CRANK;
                  next_used[SRC_EXT] = 1'b1;
               end else if (avail[SRC_SVC]) begin
                  next_cur_src = 2'(SRC_SVC);
                  next_timer = 16'h0000;
                  next_state = ei_pkg::S_CRANK;
                  next_used[SRC_SVC] = 1'b1;
               end
            end
         end
         ei_pkg::S_DELAY: begin
            if (lock || !src_bit(avail, cur_src)) begin
               next_state = ei_pkg::S_IDLE;
            end else if (timer >= `EI_CONSIST_MS) begin
               next_crank_fault = 1'b1;
               next_state = ei_pkg::S_CRANK;
               next_timer = 16'h0000;
               next_used = next_used | src_onehot(cur_src);
            end
         end
         ei_pkg::S_CRANK: begin
            if (lock
                || engine_rpm > max_crank_rpm
                || timer >= max_crank_ms
                || !src_bit(req, cur_src)) begin
               next_state = ei_pkg::S_REST;
               next_timer = 16'h0000;
            end
         end
         ei_pkg::S_REST: begin
            // Off time lets the starter cool and the pinion stop
            if (timer >= `EI_REST_MS) begin
               next_state = ei_pkg::S_IDLE;
            end
         end
         default: begin
            next_state = ei_pkg::S_IDLE;
         end
      endcase

      next_starter_on = (next_state == ei_pkg::S_CRANK);

      if (starter_type_external) begin
         next_status = ei_pkg::STAT_EXT_TYPE;
      end else if (next_short_cnt != 2'h0) begin
         next_status = ei_pkg::STAT_SHORT;
      end else if (lock) begin
         next_status = ei_pkg::STAT_LOCKED;
      end else if (next_starter_on) begin
         next_status = ei_pkg::STAT_CRANKING;
      end else begin
         next_status = ei_pkg::STAT_OK;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= ei_pkg::S_IDLE;
         timer <= 16'h0000;
         used <= 4'h0;
         cur_src <= 2'h0;
         short_cnt <= 2'h0;
         init_timer <= 16'h0000;
         init_done <= 1'b0;
         local_block <= 1'b0;
         starter_on <= 1'b0;
         crank_fault <= 1'b0;
         starter_status <= ei_pkg::STAT_OK;
      end else begin
         state <= next_state;
         timer <= next_timer;
         used <= next_used;
         cur_src <= next_cur_src;
         short_cnt <= next_short_cnt;
         init_timer <= next_init_timer;
         init_done <= next_init_done;
         local_block <= next_local_block;
         starter_on <= next_starter_on;
         crank_fault <= next_crank_fault;
         starter_status <= next_status;
      end
   end

   // Injection, governor and torque
   logic in_hold, next_in_hold;
   logic [15:0] hold_timer, next_hold_timer;
   logic next_inject_enable, next_governors_active;
   logic [15:0] next_torque_out;
   logic [15:0] next_target_rpm;
   logic [7:0] next_idle_speed_can;
   ei_pkg::ei_gov_t next_gov_mode;
   logic inhibit;
   logic [16:0] torque_sum;

   always_comb begin
      next_in_hold = in_hold;
      next_hold_timer = hold_timer;
      if (brake_active) begin
         next_in_hold = 1'b1;
         next_hold_timer = 16'h0000;
      end else if (in_hold && ms_tick) begin
         next_hold_timer = hold_timer + 16'h0001;
         if (next_hold_timer >= `EI_BRAKE_HOLD_MS) begin
            next_in_hold = 1'b0;
         end
      end

      inhibit = brake_active | in_hold
              | can_engine_stop
              | can_starter_lock_demand
              | (engine_rpm < `EI_RUN_RPM);
      next_inject_enable = ~inhibit;

      // Torque restarts from zero so demand never steps in at once
      torque_sum = {1'b0, torque_out} + {1'b0, `EI_RAMP_STEP};
      next_torque_out = torque_out;
      if (inhibit) begin
         next_torque_out = 16'h0000;
      end else if (torque_out > torque_demand) begin
         next_torque_out = torque_demand;
      end else if (ms_tick) begin
         if (torque_sum >= {1'b0, torque_demand}) begin
            next_torque_out = torque_demand;
         end else begin
            next_torque_out = torque_sum[15:0];
         end
      end

      next_gov_mode = gov_decode(gov_req.gov_type);
      next_governors_active = (next_gov_mode != ei_pkg::GOV_NONE)
                            & ~brake_active & ~in_hold;

      next_target_rpm = gov_req.idle_rpm;
      if (next_gov_mode == ei_pkg::GOV_SPEED) begin
         if (gov_req.desired_rpm < gov_req.idle_rpm) begin
            next_target_rpm = gov_req.idle_rpm;
         end else if (gov_req.desired_rpm > gov_req.max_rpm) begin
            next_target_rpm = gov_req.max_rpm;
         end else begin
            next_target_rpm = gov_req.desired_rpm;
         end
      end

      // Speeds above 4095 rpm do not fit the report and wrap
      next_idle_speed_can =
         8'(gov_req.idle_rpm >> `EI_IDLE_RES_SHIFT);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         in_hold <= 1'b0;
         hold_timer <= 16'h0000;
         inject_enable <= 1'b0;
         torque_out <= 16'h0000;
         gov_mode <= ei_pkg::GOV_NONE;
         governors_active <= 1'b0;
         target_rpm <= 16'h0000;
         idle_speed_can <= 8'h00;
      end else begin
         in_hold <= next_in_hold;
         hold_timer <= next_hold_timer;
         inject_enable <= next_inject_enable;
         torque_out <= next_torque_out;
         gov_mode <= next_gov_mode;
         governors_active <= next_governors_active;
         target_rpm <= next_target_rpm;
         idle_speed_can <= next_idle_speed_can;
      end
   end

endmodule // ei_engine_start_interlock

// [sim/ei_start_asserts.sv]
`timescale 1ns/100ps
module ei_start_asserts (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] engine_rpm,
   input wire logic can_start_interlock,
   input wire logic can_starter_lock_demand,
   input wire logic can_engine_stop,
   input wire logic brake_active,
   input wire logic starter_type_external,
   input wire logic starter_short,
   input wire ei_pkg::ei_gov_req_t gov_req,
   input wire logic starter_on,
   input wire logic inject_enable,
   input wire ei_pkg::ei_gov_t gov_mode,
   input wire logic governors_active,
   input wire logic [7:0] idle_speed_can
);
   logic [1:0] since_rst, next_since_rst, shorts, next_shorts;
   logic live;
   // Outputs only settle from the third edge after reset
   assign live = since_rst == 2'h3;
   always_comb begin
      next_since_rst = live ? since_rst : since_rst + 2'h1;
      next_shorts = (starter_short && shorts != 2'h3) ? shorts + 2'h1 : shorts;
      if (sys_rst) begin
         next_since_rst = 2'h0;
         next_shorts = 2'h0;
      end
   end
   always_ff @(posedge clock) begin
      since_rst <= next_since_rst;
      shorts <= next_shorts;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_three_shorts;
      (shorts == 2'h3) [*2];
   endsequence
   AST_EXT_TYPE:
      assert property (starter_type_external [*2] |-> !starter_on)
      else $error("starter on with external type");
   AST_RUN_LOCK:
      assert property ((engine_rpm > 16'h0032) [*2] |-> !starter_on)
      else $error("starter on while engine runs");
   AST_CAN_ILK:
      assert property (can_start_interlock [*2] |-> !starter_on)
      else $error("starter on during interlock");
   AST_LOCK_DEM:
      assert property (can_starter_lock_demand [*2] |->
         !starter_on && !inject_enable)
      else $error("lock demand ignored");
   AST_STOP:
      assert property (can_engine_stop [*2] |-> !inject_enable)
      else $error("injection during stop");
   AST_BRAKE:
      assert property (brake_active [*2] |-> !inject_enable && !governors_active)
      else $error("injection or governor during braking");
   AST_SHORTS:
      assert property (s_three_shorts |-> !starter_on)
      else $error("starter on after three shorts");
   AST_IDLE_CAN:
      assert property (live && $stable(gov_req.idle_rpm) |->
         idle_speed_can == gov_req.idle_rpm[11:4])
      else $error("idle speed scaling wrong");
   AST_GOV_MODE:
      assert property (live && $stable(gov_req.gov_type) |-> gov_mode ==
         (gov_req.gov_type == 4'hF ? ei_pkg::GOV_IDLE :
         gov_req.gov_type <= 4'h5 ? ei_pkg::GOV_SPEED : ei_pkg::GOV_NONE))
      else $error("wrong governor mode");
endmodule // ei_start_asserts

bind ei_engine_start_interlock ei_start_asserts chk_u (.clock, .sys_rst,
   .engine_rpm, .can_start_interlock, .can_starter_lock_demand,
   .can_engine_stop, .brake_active, .starter_type_external, .starter_short,
   .gov_req, .starter_on, .inject_enable, .gov_mode, .governors_active,
   .idle_speed_can);

// [sim/ei_vc_model.sv]
`timescale 1ns/100ps
module ei_vc_model (
   input wire logic clock,
   output logic can_crank,
   output logic ext_start,
   output logic can_start_interlock,
   output logic can_starter_lock_demand,
   output logic can_engine_stop,
   output logic neutral_position,
   output ei_pkg::ei_gov_req_t gov_req
);
   // Order: crank, ext start, interlock, lock demand, stop, neutral
   logic [5:0] flags = 6'h00;
   assign {can_crank, ext_start, can_start_interlock, can_starter_lock_demand,
      can_engine_stop, neutral_position} = flags;
   initial gov_req = {16'h02A0, 16'h0800, 16'h0400, 4'hE};
   task automatic send(input logic [5:0] f);
      @(negedge clock);
      flags = f;
   endtask
   // A start flag drops for one clock before it is raised again
   task automatic rearm(input logic [5:0] f);
      send(f & 6'h0F);
      send(f);
   endtask
   task automatic select(input ei_pkg::ei_gov_req_t g);
      @(negedge clock);
      gov_req = g;
   endtask
endmodule // ei_vc_model

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
   localparam int MS = 4;
   localparam int REST = 1010 * MS;
   localparam logic [5:0] CRANK = 6'h20, EXT = 6'h10, ILK = 6'h08;
   localparam logic [5:0] LKD = 6'h04, STOP = 6'h02, NEU = 6'h01;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic local_crank = 1'b0, service = 1'b0, ignition_on = 1'b1;
   logic brake_active = 1'b0, auto_tx = 1'b0, ext_type = 1'b0;
   logic starter_short = 1'b0, reset_bridge = 1'b0;
   logic [15:0] crank_ms = 16'h0014;
   logic [15:0] rpm = 16'h0000, crank_rpm = 16'h0028, torque = 16'h0040;
   logic can_crank, ext_start, can_ilk, lock_dem, can_stop, neutral;
   logic starter_on, inject_enable, crank_fault, governors_active;
   ei_pkg::ei_gov_req_t gov_req;
   ei_pkg::ei_stat_t starter_status;
   ei_pkg::ei_gov_t gov_mode;
   logic [7:0] idle_speed_can;
   logic [15:0] target_rpm, torque_out;
   logic [15:0] desired [3] = '{16'h0100, 16'h0400, 16'h0900};
   logic [15:0] clamped [3] = '{16'h02A0, 16'h0400, 16'h0800};
   int n_fail = 0, check_count = 0;
   always #5 clock = ~clock;
   ei_vc_model vc_u (.clock, .can_crank, .ext_start,
      .can_start_interlock(can_ilk), .can_starter_lock_demand(lock_dem),
      .can_engine_stop(can_stop), .neutral_position(neutral), .gov_req);
   ei_engine_start_interlock #(.MS_CYCLES(MS)) dut_u (.clock, .sys_rst,
      .src({local_crank, can_crank, ext_start, service}), .ignition_on,
      .reset_bridge, .engine_rpm(rpm), .max_crank_rpm(crank_rpm),
      .max_crank_ms(crank_ms), .can_start_interlock(can_ilk),
      .can_starter_lock_demand(lock_dem), .can_engine_stop(can_stop),
      .brake_active, .auto_transmission(auto_tx),
      .neutral_position(neutral), .starter_type_external(ext_type),
      .starter_short, .gov_req, .torque_demand(torque), .starter_on,
      .inject_enable, .crank_fault, .starter_status, .gov_mode,
      .governors_active, .idle_speed_can, .target_rpm, .torque_out);
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_for(input bit inj, input logic want, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         if ((inj ? inject_enable : starter_on) === want) break;
         @(negedge clock);
      end
      check(16'(inj ? inject_enable : starter_on), 16'(want));
      if (i == lim) close_out();
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   initial begin
      ei_pkg::ei_gov_t exp_mode;
      step(6);
      sys_rst = 1'b0;
      ext_type = 1'b1;
      vc_u.send(EXT);
      step(5);
      check(16'(starter_on), 16'h0000);
      check(16'(starter_status), 16'(ei_pkg::STAT_EXT_TYPE));
      vc_u.send(6'h00);
      ext_type = 1'b0;
      done("ext_type");
      vc_u.send(EXT);
      wait_for(0, 1'b1, 3);
      check(16'(starter_status), 16'(ei_pkg::STAT_CRANKING));
      step(18 * MS);
      check(16'(starter_on), 16'h0001);
      wait_for(0, 1'b0, 6 * MS);
      step(REST);
      check(16'(starter_on), 16'h0000);
      vc_u.rearm(EXT);
      wait_for(0, 1'b1, 3);
      vc_u.send(6'h00);
      wait_for(0, 1'b0, 3);
      done("timeout");
      service = 1'b1;
      step(990 * MS);
      check(16'(starter_on), 16'h0000);
      wait_for(0, 1'b1, 30 * MS);
      rpm = 16'h002D;
      wait_for(0, 1'b0, 3);
      check(16'(inject_enable), 16'h0000);
      rpm = 16'h0032;
      wait_for(1, 1'b1, 3);
      service = 1'b0;
      rpm = 16'h0000;
      crank_rpm = 16'h0100;
      crank_ms = 16'h0100;
      step(REST);
      done("rest");
      rpm = 16'h0033;
      service = 1'b1;
      step(5);
      check(16'(starter_on), 16'h0000);
      check(16'(starter_status), 16'(ei_pkg::STAT_LOCKED));
      rpm = 16'h0000;
      wait_for(0, 1'b1, 3);
      vc_u.send(ILK);
      wait_for(0, 1'b0, 3);
      service = 1'b0;
      auto_tx = 1'b1;
      vc_u.send(6'h00);
      step(REST);
      service = 1'b1;
      step(5);
      check(16'(starter_on), 16'h0000);
      vc_u.send(NEU);
      wait_for(0, 1'b1, 3);
      vc_u.send(NEU | LKD);
      wait_for(0, 1'b0, 3);
      service = 1'b0;
      auto_tx = 1'b0;
      vc_u.send(6'h00);
      step(REST);
      done("locks");
      ignition_on = 1'b0;
      local_crank = 1'b1;
      step(1010 * MS);
      check(16'(starter_on), 16'h0000);
      vc_u.send(CRANK);
      ignition_on = 1'b1;
      service = 1'b1;
      wait_for(0, 1'b1, 3);
      service = 1'b0;
      step(3);
      check(16'(starter_on), 16'h0001);
      local_crank = 1'b0;
      wait_for(0, 1'b0, 3);
      vc_u.send(6'h00);
      step(REST);
      done("priority");
      local_crank = 1'b1;
      step(990 * MS);
      check(16'(starter_on), 16'h0000);
      check(16'(crank_fault), 16'h0000);
      wait_for(0, 1'b1, 30 * MS);
      check(16'(crank_fault), 16'h0001);
      local_crank = 1'b0;
      step(REST);
      vc_u.send(CRANK);
      step(990 * MS);
      check(16'(starter_on), 16'h0000);
      wait_for(0, 1'b1, 30 * MS);
      vc_u.send(6'h00);
      step(REST);
      done("consistency");
      repeat (3) begin
         starter_short = 1'b1;
         step(1);
         starter_short = 1'b0;
         step(2);
         check(16'(starter_status), 16'(ei_pkg::STAT_SHORT));
      end
      service = 1'b1;
      step(5);
      check(16'(starter_on), 16'h0000);
      service = 1'b0;
      done("shorts");
      for (int t = 0; t < 16; t++) begin
         vc_u.select({16'h02A0, 16'h0800, 16'h0400, 4'(t)});
         step(2);
         exp_mode = t == 15 ? ei_pkg::GOV_IDLE :
            t <= 5 ? ei_pkg::GOV_SPEED : ei_pkg::GOV_NONE;
         check(16'(gov_mode), 16'(exp_mode));
         check(16'(idle_speed_can), 16'h002A);
      end
      foreach (desired[i]) begin
         vc_u.select({16'h02A0, 16'h0800, desired[i], 4'h1});
         step(2);
         check(target_rpm, clamped[i]);
      end
      done("governor");
      vc_u.select({16'h02A0, 16'h0800, 16'h0400, 4'hF});
      rpm = 16'h0200;
      step(3);
      check(16'(governors_active), 16'h0001);
      brake_active = 1'b1;
      step(3);
      check(16'(inject_enable), 16'h0000);
      check(16'(governors_active), 16'h0000);
      brake_active = 1'b0;
      step(490 * MS);
      check(16'(inject_enable), 16'h0000);
      wait_for(1, 1'b1, 20 * MS);
      check(16'(torque_out < torque), 16'h0001);
      step(6 * MS);
      check(torque_out, torque);
      torque = 16'h0020;
      step(2);
      check(torque_out, 16'h0020);
      vc_u.send(STOP);
      step(2);
      check(16'(inject_enable), 16'h0000);
      vc_u.send(6'h00);
      done("injection");
      sys_rst = 1'b1;
      local_crank = 1'b1;
      rpm = 16'h0000;
      step(6);
      sys_rst = 1'b0;
      step(1100 * MS);
      check(16'(starter_on), 16'h0000);
      done("powerup");
      sys_rst = 1'b1;
      reset_bridge = 1'b1;
      vc_u.send(CRANK);
      step(6);
      sys_rst = 1'b0;
      wait_for(0, 1'b1, 3);
      check(16'(crank_fault), 16'h0000);
      done("bridge");
      close_out();
   end
endmodule // testbench
